// >>> verilog/pmtr_pkg.sv
// Package of constants and types for the program memory table-read block.
`default_nettype none
package pmtr_pkg;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned MEM_WORDS = 2048;
  localparam int unsigned RESERVED_WORDS = 16;
  localparam int unsigned USABLE_WORDS = MEM_WORDS - RESERVED_WORDS;
  localparam logic [10:0] RESET_VECTOR = 11'h000;
  localparam logic [2:0] LAST_PAGE_HI = 3'h7;
  localparam logic [7:0] TBL_LOW_RST = 8'h00;
  localparam logic [2:0] TBL_HIGH_RST = 3'h0;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam int unsigned TABLE_OP_CYCLES = 2;
  localparam int unsigned SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    PMTR_IDLE = 2'b00,
    PMTR_FETCH = 2'b01,
    PMTR_DONE = 2'b11
  } pmtr_state_t;
endpackage : pmtr_pkg
`default_nettype wire

// >>> verilog/pmtr_table_read.sv
// Program memory with table pointer, table-read sequencing and debug/programming pin handling.
//
// Functional notes
// - Memory is 16-bit words; last 16 words reserved, reads there return zero.
// - Any reset sets the fetch address to word zero.
// - Table words may sit anywhere, addressed by a pointer separate from the PC.
// - Low and high table pointers together form the full table-read address.
// - Table read delivers the word's low byte to the operand register.
// - Table read overwrites the high-byte latch with the word's high byte.
// - High-byte latch is read-only; software writes never change it.
// - Every table operation takes two instruction cycles until data is ready.
// - Programming uses a serial link: one data line, a clock and a select.
// - Debug data line is bidirectional; debug clock line is input only.
// - Shared pin functions are inert while debugging is active.
`default_nettype none
module pmtr_table_read #(
  parameter int unsigned MEM_WORDS = pmtr_pkg::MEM_WORDS,
  parameter int unsigned RESERVED_WORDS = pmtr_pkg::RESERVED_WORDS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction cycle enable from the core divider
  input wire logic cycle_en,
  // Table pointer writes from the core
  input wire logic tbl_low_we,
  input wire logic tbl_high_we,
  input wire logic [7:0] tbl_wdata,
  // Table read requests
  input wire logic table_read_op,
  input wire logic table_read_last_page_op,
  input wire logic [7:0] dest_reg_addr,
  input wire logic latch_we,
  // Program fetch
  input wire logic [10:0] pc_addr,
  output logic [15:0] fetch_word,
  output logic [10:0] reset_fetch_addr,
  // Table read results
  output logic busy,
  output logic result_valid,
  output logic [7:0] result_low_byte,
  output logic [7:0] result_dest_addr,
  output logic [7:0] table_high_byte_latch,
  // Memory load port used during in-circuit programming
  input wire logic prog_we,
  input wire logic [10:0] prog_addr,
  input wire logic [15:0] prog_wdata,
  // Programming pins
  input wire logic prog_active,
  input wire logic prog_data_line_in,
  output logic prog_data_line_out,
  output logic prog_data_line_oe,
  input wire logic prog_serial_line_in,
  output logic prog_sample_data,
  output logic prog_sample_clk,
  // Debug pins and the shared function behind them
  input wire logic debug_enable,
  input wire logic debug_data_line_in,
  output logic debug_data_line_out,
  output logic debug_data_line_oe,
  input wire logic debug_clock_line,
  output logic debug_data_sample,
  output logic debug_clock_sample,
  input wire logic debug_data_drive,
  input wire logic debug_data_value,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe,
  input wire logic prog_data_drive,
  input wire logic prog_data_value
);

  ////////////////////////////////////////////////////////////////////////////
  // Program memory
  localparam int unsigned USABLE = MEM_WORDS - RESERVED_WORDS;
  logic [15:0] mem [0:MEM_WORDS-1];
  logic [10:0] rd_addr;
  logic [15:0] rd_word;

  always_ff @(posedge clk) begin
    if (prog_we && (32'(prog_addr) < USABLE)) begin
      mem[prog_addr] <= prog_wdata;
    end
  end

  // Reserved words read as zero so table code cannot reach them.
  always_comb begin
    if (32'(rd_addr) < USABLE) begin
      rd_word = mem[rd_addr];
    end else begin
      rd_word = pmtr_pkg::WORD_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch path and reset vector
  logic [15:0] fetch_word_d, fetch_word_q;
  logic [15:0] fetch_raw;
  logic [10:0] reset_fetch_addr_d, reset_fetch_addr_q;
  logic [10:0] fetch_addr;

  always_comb begin
    fetch_addr = rst ? pmtr_pkg::RESET_VECTOR : pc_addr;
    if (32'(fetch_addr) < USABLE) begin
      fetch_raw = mem[fetch_addr];
    end else begin
      fetch_raw = pmtr_pkg::WORD_RST;
    end
    fetch_word_d = fetch_raw;
    reset_fetch_addr_d = pmtr_pkg::RESET_VECTOR;
  end

  always_ff @(posedge clk) begin
    fetch_word_q <= fetch_word_d; // Keeps loading during reset, so word zero waits at release.
    if (rst) begin
      reset_fetch_addr_q <= pmtr_pkg::RESET_VECTOR;
    end else begin
      reset_fetch_addr_q <= reset_fetch_addr_d;
    end
  end

  assign fetch_word = fetch_word_q;
  assign reset_fetch_addr = reset_fetch_addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Table pointer and table-read sequencer
  pmtr_pkg::pmtr_state_t state_d, state_q;
  logic [7:0] tbl_low_d, tbl_low_q;
  logic [2:0] tbl_high_d, tbl_high_q;
  logic [10:0] op_addr_d, op_addr_q;
  logic [7:0] dest_d, dest_q;
  logic [7:0] latch_d, latch_q;
  logic [7:0] low_d, low_q;
  logic valid_d, valid_q, busy_q;

  assign rd_addr = op_addr_q;

  always_comb begin
    state_d = state_q;
    tbl_low_d = tbl_low_q;
    tbl_high_d = tbl_high_q;
    op_addr_d = op_addr_q;
    dest_d = dest_q;
    latch_d = latch_q;
    low_d = low_q;
    valid_d = 1'b0;
    // The pointer is its own register, untouched by program flow.
    if (tbl_low_we) begin
      tbl_low_d = tbl_wdata;
    end
    if (tbl_high_we) begin
      tbl_high_d = tbl_wdata[2:0];
    end
    // Writes aimed at the latch are dropped on purpose: nothing restores it.
    case (state_q)
      pmtr_pkg::PMTR_IDLE: begin
        if (cycle_en && (table_read_op || table_read_last_page_op)) begin
          if (table_read_last_page_op) begin
            op_addr_d = {pmtr_pkg::LAST_PAGE_HI, tbl_low_q};
          end else begin
            op_addr_d = {tbl_high_q, tbl_low_q};
          end
          dest_d = dest_reg_addr;
          state_d = pmtr_pkg::PMTR_FETCH;
        end
      end
      pmtr_pkg::PMTR_FETCH: begin
        // Second instruction cycle ends the operation.
        if (cycle_en) begin
          low_d = rd_word[7:0];
          latch_d = rd_word[15:8];
          valid_d = 1'b1;
          state_d = pmtr_pkg::PMTR_DONE;
        end
      end
      pmtr_pkg::PMTR_DONE: begin
        state_d = pmtr_pkg::PMTR_IDLE;
      end
      default: begin
        state_d = pmtr_pkg::PMTR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= pmtr_pkg::PMTR_IDLE;
      tbl_low_q <= pmtr_pkg::TBL_LOW_RST;
      tbl_high_q <= pmtr_pkg::TBL_HIGH_RST;
      op_addr_q <= pmtr_pkg::RESET_VECTOR;
      dest_q <= pmtr_pkg::LATCH_RST;
      latch_q <= pmtr_pkg::LATCH_RST;
      low_q <= pmtr_pkg::LATCH_RST;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tbl_low_q <= tbl_low_d;
      tbl_high_q <= tbl_high_d;
      op_addr_q <= op_addr_d;
      dest_q <= dest_d;
      latch_q <= latch_d;
      low_q <= low_d;
      valid_q <= valid_d;
      busy_q <= (state_d == pmtr_pkg::PMTR_FETCH);
    end
  end

  assign busy = busy_q;
  assign result_valid = valid_q;
  assign result_low_byte = low_q;
  assign result_dest_addr = dest_q;
  assign table_high_byte_latch = latch_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs: three flip-flops, a change counts when stages two and three agree
  localparam int unsigned NPIN = 4;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_filt_d, pin_filt_q;
  logic [NPIN-1:0] s1_q, s2_q, s3_q;
  assign pin_raw = {debug_clock_line, debug_data_line_in, prog_serial_line_in, prog_data_line_in};

  generate
    for (genvar gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
      always_comb begin
        pin_filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : pin_filt_q[gi];
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          pin_filt_q[gi] <= 1'b0;
        end else begin
          pin_filt_q[gi] <= pin_filt_d[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  logic pdo_d, pdo_q, pdoe_d, pdoe_q, ddo_d, ddo_q, ddoe_d, ddoe_q;
  logic psd_d, psd_q, psc_d, psc_q, dds_d, dds_q, dcs_d, dcs_q;

  always_comb begin
    // Serial link: data line may turn around, clock line only listens.
    pdo_d = prog_data_value;
    pdoe_d = prog_active && prog_data_drive;
    psd_d = prog_active ? pin_filt_q[0] : 1'b0;
    // While programming, the debug data pin is released unless debugging is enabled.
    psc_d = prog_active ? pin_filt_q[1] : 1'b0;
    // Debug data turns around; debug clock is sampled only.
    if (debug_enable) begin
      ddo_d = debug_data_value;
      ddoe_d = debug_data_drive;
    end else if (prog_active) begin
      ddo_d = 1'b0;
      ddoe_d = 1'b0;
    end else begin
      ddo_d = shared_pin_out;
      ddoe_d = shared_pin_oe;
    end
    // Shared function is cut off while debugging.
    dds_d = debug_enable ? pin_filt_q[2] : 1'b0;
    dcs_d = debug_enable ? pin_filt_q[3] : 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      {pdo_q, pdoe_q, ddo_q, ddoe_q} <= 4'h0;
      {psd_q, psc_q, dds_q, dcs_q} <= 4'h0;
    end else begin
      {pdo_q, pdoe_q, ddo_q, ddoe_q} <= {pdo_d, pdoe_d, ddo_d, ddoe_d};
      {psd_q, psc_q, dds_q, dcs_q} <= {psd_d, psc_d, dds_d, dcs_d};
    end
  end

  assign prog_data_line_out = pdo_q;
  assign prog_data_line_oe = pdoe_q;
  assign prog_sample_data = psd_q;
  assign prog_sample_clk = psc_q;
  assign debug_data_line_out = ddo_q;
  assign debug_data_line_oe = ddoe_q;
  assign debug_data_sample = dds_q;
  assign debug_clock_sample = dcs_q;

endmodule : pmtr_table_read
`default_nettype wire

// >>> verif/pmtr_checker.sv
// Port assertions for the table-read block.
`default_nettype none
module pmtr_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Table read
  input wire logic cycle_en,
  input wire logic table_read_op,
  input wire logic table_read_last_page_op,
  input wire logic busy,
  input wire logic result_valid,
  input wire logic [7:0] result_low_byte,
  input wire logic [7:0] table_high_byte_latch,
  input wire logic [10:0] reset_fetch_addr,
  // Debug pins
  input wire logic debug_enable,
  input wire logic debug_data_drive,
  input wire logic debug_data_line_oe,
  input wire logic debug_clock_sample
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_start; $rose(busy) |-> $past(cycle_en && (table_read_op || table_read_last_page_op)); endproperty
  a_start: assert property (p_start) else $error("busy without an accepted read");
  property p_done; $fell(busy) |-> result_valid; endproperty
  a_done: assert property (p_done) else $error("read ended without result");
  property p_pulse; result_valid |=> !result_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("result pulse too long");
  property p_bound; $rose(busy) |-> ##[1:12] result_valid; endproperty
  a_bound: assert property (p_bound) else $error("read never completed");
  property p_latch; $changed(table_high_byte_latch) |-> result_valid; endproperty
  a_latch: assert property (p_latch) else $error("latch moved outside a read");
  property p_low; $changed(result_low_byte) |-> result_valid; endproperty
  a_low: assert property (p_low) else $error("low byte moved outside a read");
  property p_rvec; reset_fetch_addr == pmtr_pkg::RESET_VECTOR; endproperty
  a_rvec: assert property (p_rvec) else $error("reset vector wrong");
  property p_dbg_oe; debug_enable [*6] |-> debug_data_line_oe == $past(debug_data_drive); endproperty
  a_dbg_oe: assert property (p_dbg_oe) else $error("debug pin not under debug control");
  property p_dbg_smp; !debug_enable [*6] |-> !debug_clock_sample; endproperty
  a_dbg_smp: assert property (p_dbg_smp) else $error("debug clock seen while off");
  c_read: cover property (result_valid);
  c_slow: cover property (busy [*3]);
  c_dbg: cover property (debug_enable && debug_data_line_oe);
endmodule : pmtr_checker
bind pmtr_table_read pmtr_checker chk_inst (.clk, .rst, .cycle_en, .table_read_op, .table_read_last_page_op,
  .busy, .result_valid, .result_low_byte, .table_high_byte_latch, .reset_fetch_addr, .debug_enable,
  .debug_data_drive, .debug_data_line_oe, .debug_clock_sample);
`default_nettype wire

// >>> verif/pmtr_core_model.sv
// Core model: instruction-cycle enable and table-read requests.
`default_nettype none
module pmtr_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pace and status
  input wire logic slow,
  input wire logic busy,
  input wire logic result_valid,
  // Requests
  output logic cycle_en = 1'b0,
  output logic table_read_op = 1'b0,
  output logic table_read_last_page_op = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q = 2'h0;
  always @(negedge clk) begin
    div_q <= rst ? 2'h0 : div_q + 2'h1;
    cycle_en <= !slow || div_q == 2'h3;
  end
  // Reads never overlap, so the shared latch is not clobbered mid-use.
  task automatic rd(input logic full, input logic last, output int n);
    n = 0;
    @(negedge clk);
    table_read_op = full;
    table_read_last_page_op = last;
    while (!busy && n < 40) begin
      @(negedge clk);
      n++;
    end
    table_read_op = 1'b0;
    table_read_last_page_op = 1'b0;
    while (!result_valid && n < 40) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
  endtask : rd
endmodule : pmtr_core_model
`default_nettype wire

// >>> verif/pmtr_table_read_test.sv
// Self-checking bench for the table-read block.
`default_nettype none
module pmtr_table_read_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, slow = 1'b0, ext_dbg = 1'b1;
  logic cycle_en, table_read_op, table_read_last_page_op;
  logic tbl_low_we = 1'b0, tbl_high_we = 1'b0, latch_we = 1'b0, prog_we = 1'b0;
  logic [7:0] tbl_wdata = 8'h00, dest_reg_addr = 8'h00;
  logic [10:0] pc_addr = 11'h000, prog_addr = 11'h000;
  logic [15:0] prog_wdata = 16'h0000;
  logic prog_active = 1'b0, prog_serial_line_in = 1'b0, prog_data_drive = 1'b0, prog_data_value = 1'b0;
  logic debug_enable = 1'b0, debug_clock_line = 1'b0, debug_data_drive = 1'b0, debug_data_value = 1'b0;
  logic shared_pin_out = 1'b0, shared_pin_oe = 1'b0;
  logic [15:0] fetch_word;
  logic [10:0] reset_fetch_addr;
  logic busy, result_valid, prog_data_line_out, prog_data_line_oe, prog_sample_data, prog_sample_clk;
  logic debug_data_line_out, debug_data_line_oe, debug_data_sample, debug_clock_sample;
  logic [7:0] result_low_byte, result_dest_addr, table_high_byte_latch;
  int error_cnt = 0, total_checks = 0;
  // Pins are pulled up when nobody drives them.
  wire logic prog_data_line_in = prog_data_line_oe ? prog_data_line_out : 1'b1;
  wire logic debug_data_line_in = debug_data_line_oe ? debug_data_line_out : ext_dbg;
  pmtr_table_read pmtr_table_read_inst (.clk, .rst, .cycle_en, .tbl_low_we, .tbl_high_we, .tbl_wdata,
    .table_read_op, .table_read_last_page_op, .dest_reg_addr, .latch_we, .pc_addr, .fetch_word,
    .reset_fetch_addr, .busy, .result_valid, .result_low_byte, .result_dest_addr, .table_high_byte_latch,
    .prog_we, .prog_addr, .prog_wdata, .prog_active, .prog_data_line_in, .prog_data_line_out,
    .prog_data_line_oe, .prog_serial_line_in, .prog_sample_data, .prog_sample_clk, .debug_enable,
    .debug_data_line_in, .debug_data_line_out, .debug_data_line_oe, .debug_clock_line, .debug_data_sample,
    .debug_clock_sample, .debug_data_drive, .debug_data_value, .shared_pin_out, .shared_pin_oe,
    .prog_data_drive, .prog_data_value);
  pmtr_core_model pmtr_core_model_inst (.clk, .rst, .slow, .busy, .result_valid, .cycle_en, .table_read_op,
    .table_read_last_page_op);
  initial forever #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic ld(input logic [10:0] a, input logic [15:0] d);
    @(negedge clk);
    prog_we = 1'b1;
    prog_addr = a;
    prog_wdata = d;
    @(negedge clk);
    prog_we = 1'b0;
  endtask : ld
  task automatic ptr(input logic [7:0] hi, input logic [7:0] lo);
    @(negedge clk);
    tbl_wdata = hi;
    tbl_high_we = 1'b1;
    @(negedge clk);
    tbl_high_we = 1'b0;
    tbl_low_we = 1'b1;
    tbl_wdata = lo;
    @(negedge clk);
    tbl_low_we = 1'b0;
  endtask : ptr
  task automatic rd_chk(input logic f, input logic l, input logic [7:0] dst, input logic [15:0] w);
    int n;
    dest_reg_addr = dst;
    pmtr_core_model_inst.rd(f, l, n);
    chk("low", {8'h00, w[7:0]}, {8'h00, result_low_byte});
    chk("latch", {8'h00, w[15:8]}, {8'h00, table_high_byte_latch});
    chk("dest", {8'h00, dst}, {8'h00, result_dest_addr});
    if (!slow) chk("cycles", 16'(pmtr_pkg::TABLE_OP_CYCLES), n[15:0]);
  endtask : rd_chk
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_load;
    prog_active = 1'b1;
    ld(11'h000, 16'h0F1E);
    ld(11'h123, 16'hA55A);
    ld(11'h706, 16'h3C1A);
    ld(11'h006, 16'h7788);
    ld(11'h7EF, 16'hBEEF);
    ld(11'h7F0, 16'hDEAD);
    prog_active = 1'b0;
    pc_addr = 11'h123;
    repeat (3) @(negedge clk);
    chk("fetch", 16'hA55A, fetch_word);
    pc_addr = 11'h7F0;
    repeat (3) @(negedge clk);
    chk("reserved fetch", 16'h0000, fetch_word);
    $display("t_load done");
  endtask : t_load
  task automatic t_reads;
    ptr(8'h01, 8'h23);
    rd_chk(1'b1, 1'b0, 8'h40, 16'hA55A);
    ptr(8'h00, 8'h06);
    rd_chk(1'b1, 1'b0, 8'h41, 16'h7788);
    rd_chk(1'b0, 1'b1, 8'h42, 16'h3C1A);
    rd_chk(1'b1, 1'b1, 8'h43, 16'h3C1A);
    ptr(8'h07, 8'hF0);
    rd_chk(1'b1, 1'b0, 8'h44, 16'h0000);
    ptr(8'h07, 8'hEF);
    rd_chk(1'b1, 1'b0, 8'h45, 16'hBEEF);
    tbl_wdata = 8'h55;
    latch_we = 1'b1;
    @(negedge clk);
    latch_we = 1'b0;
    repeat (2) @(negedge clk);
    chk("latch kept", 16'h00BE, {8'h00, table_high_byte_latch});
    slow = 1'b1;
    ptr(8'h01, 8'h23);
    rd_chk(1'b1, 1'b0, 8'h46, 16'hA55A);
    slow = 1'b0;
    $display("t_reads done");
  endtask : t_reads
  task automatic t_pins;
    prog_active = 1'b1;
    prog_data_drive = 1'b1;
    prog_data_value = 1'b1;
    prog_serial_line_in = 1'b1;
    shared_pin_out = 1'b1;
    shared_pin_oe = 1'b1;
    repeat (8) @(negedge clk);
    chk("prog oe", 16'h0001, {15'h0, prog_data_line_oe});
    chk("prog out", 16'h0001, {15'h0, prog_data_line_out});
    chk("prog data", 16'h0001, {15'h0, prog_sample_data});
    chk("prog clk", 16'h0001, {15'h0, prog_sample_clk});
    chk("dbg oe prog", 16'h0000, {15'h0, debug_data_line_oe});
    prog_active = 1'b0;
    debug_enable = 1'b1;
    debug_data_drive = 1'b1;
    debug_clock_line = 1'b1;
    repeat (8) @(negedge clk);
    chk("dbg out", 16'h0002, {14'h0, debug_data_line_oe, debug_data_line_out});
    chk("dbg clk", 16'h0001, {15'h0, debug_clock_sample});
    debug_data_drive = 1'b0;
    repeat (8) @(negedge clk);
    chk("dbg in", 16'h0001, {15'h0, debug_data_sample});
    debug_enable = 1'b0;
    repeat (8) @(negedge clk);
    chk("shared out", 16'h0003, {14'h0, debug_data_line_oe, debug_data_line_out});
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk("reset fetch", 16'h0F1E, fetch_word);
    rst = 1'b0;
    @(negedge clk);
    chk("latch reset", 16'h0000, {8'h00, table_high_byte_latch});
    chk("vector", 16'h0000, {5'h00, reset_fetch_addr});
    $display("t_pins done");
  endtask : t_pins
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_load;
    t_reads;
    t_pins;
    print_verdict;
  end
  initial begin
    #40000;
    error_cnt++;
    print_verdict;
  end
endmodule : pmtr_table_read_test
`default_nettype wire
